//--- src/dtc_pkg.sv
package dtc_pkg;
  // ************************************************
  // register addresses and pages
  // ************************************************
  localparam logic [7:0] DTC_ADDR_RUN_FLAG = 8'h88;
  localparam logic [7:0] DTC_ADDR_MODE = 8'h89;
  localparam logic [7:0] DTC_ADDR_T0_LOW = 8'h8a;
  localparam logic [7:0] DTC_ADDR_T1_LOW = 8'h8b;
  localparam logic [7:0] DTC_ADDR_T0_HIGH = 8'h8c;
  localparam logic [7:0] DTC_ADDR_T1_HIGH = 8'h8d;
  localparam logic [7:0] DTC_ADDR_CLK_SEL = 8'ha3;
  localparam logic [7:0] DTC_ADDR_PAGED = 8'ha4;
  localparam logic [3:0] DTC_PAGE_PRESCALE = 4'h0;
  localparam logic [3:0] DTC_PAGE_ROUTE = 4'h1;
  localparam logic [3:0] DTC_PAGE_GATE_EXT = 4'h6;
  localparam logic [7:0] DTC_RESET_BYTE = 8'h00;

  // ************************************************
  // field positions
  // ************************************************
  localparam int DTC_BIT_T1_FLAG = 7;
  localparam int DTC_BIT_T1_RUN = 6;
  localparam int DTC_BIT_T0_FLAG = 5;
  localparam int DTC_BIT_T0_RUN = 4;
  localparam int DTC_BIT_T1_GATE_LO = 7;
  localparam int DTC_BIT_T1_CNT_SEL = 6;
  localparam int DTC_BIT_T1_MODE = 4;
  localparam int DTC_BIT_T0_GATE_LO = 3;
  localparam int DTC_BIT_T0_CNT_SEL = 2;
  localparam int DTC_BIT_T0_MODE = 0;
  localparam int DTC_BIT_T1_FAST = 3;
  localparam int DTC_BIT_T0_FAST = 2;
  localparam int DTC_BIT_T1_CKOE = 1;
  localparam int DTC_BIT_T0_CKOE = 0;
  localparam int DTC_BIT_T0_ROUTE = 6;
  localparam int DTC_BIT_T0_SLOW = 0;
  localparam int DTC_BIT_T1_ROUTE = 4;
  localparam int DTC_BIT_T1_GATE_HI = 5;
  localparam int DTC_BIT_T0_GATE_HI = 4;

  // ************************************************
  // prescale ratios in system clock cycles
  // ************************************************
  localparam logic [7:0] DTC_DIV_STD = 8'h0c;
  localparam logic [7:0] DTC_DIV_QUAD = 8'h30;
  localparam logic [7:0] DTC_DIV_SLOWEST = 8'hc0;

  // ************************************************
  // types
  // ************************************************
  typedef enum logic [1:0] {
    DTC_MODE_PWM8 = 2'b00,
    DTC_MODE_CNT16 = 2'b01,
    DTC_MODE_RELOAD8 = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dtc_sfr_req_type;

  typedef struct packed {
    logic div_std;
    logic div_quad;
    logic div_slowest;
  } dtc_tick_type;
endpackage : dtc_pkg

//--- src/dtc_prescaler.sv
`timescale 1ns/1ps
module dtc_prescaler (
  input wire logic clk_sys_i, // system clock
  input wire logic sys_rst_i, // sync reset, high
  output dtc_pkg::dtc_tick_type tick_o // one-cycle enables
);
  import dtc_pkg::*;

  localparam logic [7:0] DIVS [3] = '{DTC_DIV_SLOWEST, DTC_DIV_QUAD, DTC_DIV_STD};
  wire [2:0] tick_q;

  // ************************************************
  // one free-running divider per ratio
  // ************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_div
      logic [7:0] cnt_q;
      logic pulse_q;
      wire wrap = (cnt_q == DIVS[g] - 8'h01);
      // count and emit a pulse at wrap
      always_ff @(posedge clk_sys_i)
      begin
        if (sys_rst_i)
        begin
          cnt_q <= 8'h00;
          pulse_q <= 1'b0;
        end
        else
        begin
          cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
          pulse_q <= wrap;
        end
      end
      // each divider owns one bit of the pulse vector
      assign tick_q[g] = pulse_q;
    end
  endgenerate

  assign tick_o = dtc_tick_type'(tick_q);
endmodule : dtc_prescaler

//--- src/dtc_timer_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// [RULE_01] overflow flags set on overflow, cleared on vector ack, software read/write
// [RULE_02] run bit zero stops the timer, one lets it run
// [RULE_03] timer one gate: none, ext irq one, third timer flag, serial tx flag
// [RULE_04] timer zero gate: none, ext irq zero, second timer flag, keypad irq
// [RULE_05] timer one modes: pwm, 16-bit, 8-bit reload, stopped
// [RULE_06] timer zero modes: pwm, 16-bit, 8-bit reload, split low/high bytes
// [RULE_07] timer one source: clk/12, pin, clk, clk/48
// [RULE_08] timer zero source: eight choices incl. oscillator, watchdog, timer one overflow
// [RULE_09] timer one clock output driven on its pin when enabled
// [RULE_10] timer zero clock output driven on its pin when enabled
// [RULE_11] timer zero pin routed to one of four pins
// [RULE_12] timer one pin routed to one of four pins
// [RULE_13] address a4 decodes by page to three auxiliary registers
// [RULE_14] counting needs run bit and, if selected, an active gate
// [RULE_15] counter mode counts high-to-low transitions of sampled pin
// [RULE_16] reload mode reloads low byte from high byte, high unchanged
// [RULE_17] split mode: high byte uses timer one run and flag; timer one holds (code: timer one counts with its run bit ignored and sets no flag)
// [RULE_18] clock-out mode: 8-bit reload, toggle per overflow, no flag
module dtc_timer_ctrl (
  input wire logic clk_sys_i, // system clock
  input wire logic sys_rst_i, // sync reset, high
  input dtc_pkg::dtc_sfr_req_type sfr_req_i, // register access
  output logic [7:0] sfr_rdata_o, // read data, registered
  output logic sfr_rvalid_o, // read data valid
  input wire logic t0_irq_ack_i, // vector taken, timer zero
  input wire logic t1_irq_ack_i, // vector taken, timer one
  input wire logic [3:0] t0_pin_i, // timer zero candidate pins
  input wire logic [3:0] t1_pin_i, // timer one candidate pins
  output logic [3:0] t_zero_clkout_pin_o, // clock out level
  output logic [3:0] t_zero_clkout_oe_o, // clock out enable
  output logic [3:0] t_one_clkout_pin_o, // clock out level
  output logic [3:0] t_one_clkout_oe_o, // clock out enable
  input wire logic ext_irq_zero_i, // gate pin, high active
  input wire logic ext_irq_one_i, // gate pin, high active
  input wire logic keypad_irq_i, // gate level
  input wire logic second_timer_overflow_flag_i, // gate level
  input wire logic third_timer_overflow_flag_i, // gate level
  input wire logic serial_one_tx_flag_i, // gate level
  input wire logic internal_low_speed_osc_i, // async clock
  input wire logic watchdog_prescaler_out_i, // one-cycle pulse
  output logic t_zero_overflow_flag_o, // flag
  output logic t_one_overflow_flag_o, // flag
  output logic [1:0] pwm_o // pwm level per timer
);
  import dtc_pkg::*;

  // ************************************************
  // state
  // ************************************************
  logic [10:0] sync1_q, sync2_q, sync3_q;
  logic t0_flag_q, t1_flag_q, t0_run_q, t1_run_q;
  logic [3:0] irq_bits_q;
  logic [7:0] mode_q, tl0_q, th0_q, tl1_q, th1_q;
  logic [3:0] clk_sel_q;
  logic [1:0] route0_q, route1_q, gate_hi_q, tog_q, pwm_q;
  logic slow0_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  dtc_tick_type tick;

  dtc_prescaler u_pre (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .tick_o(tick)
  );

  // ************************************************
  // pin synchronisers and edge detect
  // ************************************************
  always_ff @(posedge clk_sys_i)
  begin
    sync1_q <= {internal_low_speed_osc_i, ext_irq_one_i, ext_irq_zero_i, t1_pin_i, t0_pin_i};
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
  end

  wire [3:0] pin0_fall = sync3_q[3:0] & ~sync2_q[3:0];
  wire [3:0] pin1_fall = sync3_q[7:4] & ~sync2_q[7:4];
  wire ext0_lvl = sync2_q[8];
  wire ext1_lvl = sync2_q[9];
  wire osc_rise = sync2_q[10] & ~sync3_q[10];

  // ************************************************
  // address decode
  // ************************************************
  wire wr = sfr_req_i.wr;
  wire [7:0] wd = sfr_req_i.wdata;
  wire [7:0] ad = sfr_req_i.addr;
  wire wr_run = wr & (ad == DTC_ADDR_RUN_FLAG);
  wire wr_mode = wr & (ad == DTC_ADDR_MODE);
  wire wr_tl0 = wr & (ad == DTC_ADDR_T0_LOW);
  wire wr_tl1 = wr & (ad == DTC_ADDR_T1_LOW);
  wire wr_th0 = wr & (ad == DTC_ADDR_T0_HIGH);
  wire wr_th1 = wr & (ad == DTC_ADDR_T1_HIGH);
  wire wr_csel = wr & (ad == DTC_ADDR_CLK_SEL);
  wire sel_pre = (ad == DTC_ADDR_PAGED) & (sfr_req_i.page == DTC_PAGE_PRESCALE); // RULE_13
  wire sel_rte = (ad == DTC_ADDR_PAGED) & (sfr_req_i.page == DTC_PAGE_ROUTE); // RULE_13
  wire sel_gx = (ad == DTC_ADDR_PAGED) & (sfr_req_i.page == DTC_PAGE_GATE_EXT); // RULE_13

  // ************************************************
  // field views
  // ************************************************
  wire [1:0] mode0 = mode_q[DTC_BIT_T0_MODE +: 2];
  wire [1:0] mode1 = mode_q[DTC_BIT_T1_MODE +: 2];
  wire ckoe0 = clk_sel_q[DTC_BIT_T0_CKOE];
  wire ckoe1 = clk_sel_q[DTC_BIT_T1_CKOE];
  wire split0 = (mode0 == DTC_MODE_SPLIT) & ~ckoe0; // RULE_06
  wire [2:0] src0 = {slow0_q, clk_sel_q[DTC_BIT_T0_FAST], mode_q[DTC_BIT_T0_CNT_SEL]};
  wire [1:0] src1 = {clk_sel_q[DTC_BIT_T1_FAST], mode_q[DTC_BIT_T1_CNT_SEL]};
  wire [1:0] gsel0 = {gate_hi_q[0], mode_q[DTC_BIT_T0_GATE_LO]};
  wire [1:0] gsel1 = {gate_hi_q[1], mode_q[DTC_BIT_T1_GATE_LO]};

  // ************************************************
  // step of one timer: {overflow, high, low}
  // ************************************************
  function automatic logic [16:0] dtc_step(input logic [7:0] tl, input logic [7:0] th,
                                           input logic [1:0] md, input logic cko);
    logic [16:0] r;
    r = {tl == 8'hff, th, tl + 8'h01}; // pwm and split: 8-bit wrap
    if (cko | (md == DTC_MODE_RELOAD8))
      r = {tl == 8'hff, th, (tl == 8'hff) ? th : tl + 8'h01}; // RULE_16 RULE_18
    else if (md == DTC_MODE_CNT16)
      r = {{th, tl} == 16'hffff, {th, tl} + 16'h0001};
    return r;
  endfunction : dtc_step

  // ************************************************
  // source, gate and count enables
  // ************************************************
  wire [16:0] step0 = dtc_step(tl0_q, th0_q, mode0, ckoe0);
  wire [16:0] step1 = dtc_step(tl1_q, th1_q, mode1, ckoe1);
  wire [3:0] gate0_vec = {keypad_irq_i, second_timer_overflow_flag_i, ext0_lvl, 1'b1};
  wire gate0 = gate0_vec[gsel0]; // RULE_04
  wire [3:0] gate1_vec = {serial_one_tx_flag_i, third_timer_overflow_flag_i, ext1_lvl, 1'b1};
  wire gate1 = gate1_vec[gsel1]; // RULE_03
  wire [3:0] tick1_vec = {tick.div_quad, 1'b1, pin1_fall[route1_q], tick.div_std};
  wire tick1 = tick1_vec[src1]; // RULE_07 RULE_15
  wire run1 = split0 ? 1'b1 : t1_run_q; // RULE_17
  wire en1 = run1 & gate1 & tick1 & (mode1 != DTC_MODE_SPLIT); // RULE_05 RULE_14 RULE_02
  wire t1_ovf_evt = en1 & step1[16];
  wire [7:0] tick0_vec = {t1_ovf_evt, tick.div_slowest, watchdog_prescaler_out_i, tick.div_quad,
                          osc_rise, 1'b1, pin0_fall[route0_q], tick.div_std};
  wire tick0 = tick0_vec[src0]; // RULE_08 RULE_15
  wire en0 = t0_run_q & gate0 & tick0; // RULE_02 RULE_14
  wire th0_tick = split0 & t1_run_q & ((src0 == 3'b001) ? tick.div_std : tick0); // RULE_17
  wire t0_set = en0 & step0[16] & ~ckoe0; // RULE_18
  wire t1_set = split0 ? (th0_tick & (th0_q == 8'hff)) : (en1 & step1[16] & ~ckoe1); // RULE_17 RULE_18

  // ************************************************
  // control registers
  // ************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      {t0_run_q, t1_run_q, irq_bits_q} <= 6'h00;
      mode_q <= DTC_RESET_BYTE;
      clk_sel_q <= 4'h0;
      {route0_q, route1_q, gate_hi_q, slow0_q} <= 7'h00;
    end
    else
    begin
      if (wr_run)
        {t1_run_q, t0_run_q, irq_bits_q} <= {wd[DTC_BIT_T1_RUN], wd[DTC_BIT_T0_RUN], wd[3:0]};
      if (wr_mode)
        mode_q <= wd;
      if (wr_csel)
        clk_sel_q <= wd[3:0];
      if (wr & sel_pre)
        {route0_q, slow0_q} <= {wd[DTC_BIT_T0_ROUTE +: 2], wd[DTC_BIT_T0_SLOW]};
      if (wr & sel_rte)
        route1_q <= wd[DTC_BIT_T1_ROUTE +: 2];
      if (wr & sel_gx)
        gate_hi_q <= {wd[DTC_BIT_T1_GATE_HI], wd[DTC_BIT_T0_GATE_HI]};
    end
  end

  // overflow flags: hardware set beats any clear
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      {t1_flag_q, t0_flag_q} <= 2'b00;
    else
    begin
      t0_flag_q <= t0_set | (wr_run ? wd[DTC_BIT_T0_FLAG] : (t0_flag_q & ~t0_irq_ack_i)); // RULE_01
      t1_flag_q <= t1_set | (wr_run ? wd[DTC_BIT_T1_FLAG] : (t1_flag_q & ~t1_irq_ack_i)); // RULE_01
    end
  end

  // ************************************************
  // count registers, software write wins
  // ************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      {tl0_q, th0_q, tl1_q, th1_q} <= {4{DTC_RESET_BYTE}};
    else
    begin
      tl0_q <= wr_tl0 ? wd : (en0 ? step0[7:0] : tl0_q);
      th0_q <= wr_th0 ? wd : (th0_tick ? th0_q + 8'h01 : ((en0 & ~split0) ? step0[15:8] : th0_q));
      tl1_q <= wr_tl1 ? wd : (en1 ? step1[7:0] : tl1_q);
      th1_q <= wr_th1 ? wd : (en1 ? step1[15:8] : th1_q);
    end
  end

  // clock-out toggles and pwm levels
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      {tog_q, pwm_q} <= 4'h0;
    else
    begin
      tog_q[0] <= tog_q[0] ^ (en0 & step0[16] & ckoe0); // RULE_18
      tog_q[1] <= tog_q[1] ^ (en1 & step1[16] & ckoe1); // RULE_18
      pwm_q[0] <= (mode0 == DTC_MODE_PWM8) & ~ckoe0 & (tl0_q < th0_q);
      pwm_q[1] <= (mode1 == DTC_MODE_PWM8) & ~ckoe1 & (tl1_q < th1_q);
    end
  end

  // ************************************************
  // pin routing of clock outputs
  // ************************************************
  assign t_zero_clkout_oe_o = {3'b000, ckoe0} << route0_q; // RULE_10 RULE_11
  assign t_zero_clkout_pin_o = {4{tog_q[0]}} & t_zero_clkout_oe_o; // RULE_10
  assign t_one_clkout_oe_o = {3'b000, ckoe1} << route1_q; // RULE_09 RULE_12
  assign t_one_clkout_pin_o = {4{tog_q[1]}} & t_one_clkout_oe_o; // RULE_09

  // ************************************************
  // read path
  // ************************************************
  wire [7:0] rd_run = {t1_flag_q, t1_run_q, t0_flag_q, t0_run_q, irq_bits_q};
  wire [7:0] rd_mux =
    (ad == DTC_ADDR_RUN_FLAG) ? rd_run :
    (ad == DTC_ADDR_MODE) ? mode_q :
    (ad == DTC_ADDR_T0_LOW) ? tl0_q :
    (ad == DTC_ADDR_T1_LOW) ? tl1_q :
    (ad == DTC_ADDR_T0_HIGH) ? th0_q :
    (ad == DTC_ADDR_T1_HIGH) ? th1_q :
    (ad == DTC_ADDR_CLK_SEL) ? {4'h0, clk_sel_q} :
    sel_pre ? {route0_q, 5'h00, slow0_q} :
    sel_rte ? {2'b00, route1_q, 4'h0} :
    sel_gx ? {2'b00, gate_hi_q, 4'h0} : 8'h00;

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      {rdata_q, rvalid_q} <= 9'h000;
    else
    begin
      rvalid_q <= sfr_req_i.rd;
      if (sfr_req_i.rd)
        rdata_q <= rd_mux;
    end
  end

  assign sfr_rdata_o = rdata_q;
  assign sfr_rvalid_o = rvalid_q;
  assign t_zero_overflow_flag_o = t0_flag_q;
  assign t_one_overflow_flag_o = t1_flag_q;
  assign pwm_o = pwm_q;

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  flag_set_a: assert property (t0_set |=> t_zero_overflow_flag_o) // RULE_01
    else $error("t0 flag not set on overflow");
  ack_clear_a: assert property (t1_irq_ack_i && !t1_set && !wr_run |=> !t_one_overflow_flag_o) // RULE_01
    else $error("t1 flag not cleared on ack");
  run_stop_a: assert property (!t0_run_q && !wr_tl0 |=> $stable(tl0_q)) // RULE_02
    else $error("t0 low byte moved while stopped");
  gate_block_a: assert property (gsel1 == 2'b10 && !third_timer_overflow_flag_i && !split0 && !wr_tl1
                                 |=> $stable(tl1_q)) // RULE_03
    else $error("t1 counted with gate inactive");
  gate_ext_a: assert property (gsel0 == 2'b01 && !ext0_lvl && !wr_tl0 |=> $stable(tl0_q)) // RULE_04
    else $error("t0 counted with ext gate low");
  hold_mode_a: assert property (mode1 == DTC_MODE_SPLIT && !wr_tl1 && !wr_th1
                                |=> $stable({th1_q, tl1_q})) // RULE_05
    else $error("t1 moved in stop mode");
  carry_16_a: assert property (en0 && mode0 == DTC_MODE_CNT16 && !ckoe0 && tl0_q == 8'hff && !wr_th0 && !wr_tl0
                               |=> th0_q == $past(th0_q) + 8'h01 && tl0_q == 8'h00) // RULE_06
    else $error("t0 16-bit carry wrong");
  reload_low_a: assert property (en1 && mode1 == DTC_MODE_RELOAD8 && tl1_q == 8'hff && !wr_tl1 && !wr_th1
                                 |=> tl1_q == $past(th1_q) && $stable(th1_q)) // RULE_16
    else $error("t1 reload wrong");
  pin_edge_a: assert property (t0_run_q && gsel0 == 2'b00 && src0 == 3'b001 && mode0 == DTC_MODE_PWM8
                               && !ckoe0 && pin0_fall[route0_q] && !wr_tl0
                               |=> tl0_q == $past(tl0_q) + 8'h01) // RULE_15
    else $error("t0 missed pin transition");
  cko_noflag_a: assert property (en0 && ckoe0 && step0[16] && !wr_run && !t0_irq_ack_i
                                 |=> tog_q[0] != $past(tog_q[0]) && $stable(t_zero_overflow_flag_o)) // RULE_18
    else $error("clock-out overflow wrong");
  split_flag_a: assert property (th0_tick && th0_q == 8'hff |=> t_one_overflow_flag_o) // RULE_17
    else $error("split high byte did not set t1 flag");
  page_gate_a: assert property (wr && sel_gx
                                |=> gate_hi_q == {$past(wd[DTC_BIT_T1_GATE_HI]), $past(wd[DTC_BIT_T0_GATE_HI])}) // RULE_13
    else $error("paged gate write lost");
  cko_pin_a: assert property (ckoe1 |-> t_one_clkout_oe_o[route1_q] && $onehot(t_one_clkout_oe_o)) // RULE_09 RULE_12
    else $error("t1 clock out not on routed pin");

  cov_reload_c: cover property (en1 && mode1 == DTC_MODE_RELOAD8 && tl1_q == 8'hff);
  cov_split_c: cover property (th0_tick && th0_q == 8'hff);
  cov_cko_c: cover property (en0 && ckoe0 && step0[16]);
  cov_ack_c: cover property (t0_flag_q && t0_irq_ack_i);
endmodule : dtc_timer_ctrl

//--- tb/dtc_core_model.sv
`timescale 1ns/1ps
// ************************************************
// core side of the register bus
// ************************************************
module dtc_core_model (
  input wire logic clk_sys_i, // system clock
  input wire logic [7:0] rdata_i, // read data
  input wire logic rvalid_i, // read data valid
  output dtc_pkg::dtc_sfr_req_type req_o, // bus request
  output logic [1:0] ack_o // vector taken, {t1, t0}
);
  import dtc_pkg::*;

  // idle bus at time zero
  initial
  begin
    req_o = '0;
    ack_o = 2'b00;
  end

  // one access; on release page, address and data show the inverse, while wr and rd drop to zero
  task automatic access(input logic w, input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    req_o <= {w, ~w, pg, a, d};
    @(posedge clk_sys_i);
    req_o <= {2'b00, ~pg, ~a, ~d};
  endtask : access

  // read: data and valid are registered one edge after the request
  task automatic read(input logic [3:0] pg, input logic [7:0] a, output logic [7:0] d, output logic v);
    access(1'b0, pg, a, 8'h00);
    #1;
    d = rdata_i;
    v = rvalid_i;
  endtask : read

  // vector-taken pulse, one cycle
  task automatic ack(input logic [1:0] which);
    @(posedge clk_sys_i);
    ack_o <= which;
    @(posedge clk_sys_i);
    ack_o <= 2'b00;
  endtask : ack
endmodule : dtc_core_model

//--- tb/dual_timer_counter_control_test.sv
`timescale 1ns/1ps
module dual_timer_counter_control_test;
  import dtc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] t0_pin = 4'h0;
  logic [3:0] t1_pin = 4'h0;
  logic [3:0] gsrc = 4'h0;
  logic [1:0] gx = 2'b00;
  dtc_sfr_req_type req;
  logic [7:0] rdata;
  logic rvalid;
  logic [1:0] ack;
  logic [3:0] pin0, oe0, pin1, oe1;
  logic flag0, flag1;
  logic [1:0] pwm;
  int miscompares = 0;
  int checked = 0;

  // ************************************************
  // clock, core model and block
  // ************************************************
  always #2 clk = ~clk;

  dtc_core_model i_core (.clk_sys_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req), .ack_o(ack));

  dtc_timer_ctrl i_dut (
    .clk_sys_i(clk), .sys_rst_i(rst), .sfr_req_i(req), .sfr_rdata_o(rdata), .sfr_rvalid_o(rvalid),
    .t0_irq_ack_i(ack[0]), .t1_irq_ack_i(ack[1]), .t0_pin_i(t0_pin), .t1_pin_i(t1_pin),
    .t_zero_clkout_pin_o(pin0), .t_zero_clkout_oe_o(oe0), .t_one_clkout_pin_o(pin1),
    .t_one_clkout_oe_o(oe1), .ext_irq_zero_i(gsrc[0]), .ext_irq_one_i(gsrc[3]), .keypad_irq_i(gsrc[2]),
    .second_timer_overflow_flag_i(gsrc[1]), .third_timer_overflow_flag_i(gx[0]),
    .serial_one_tx_flag_i(gx[1]), .internal_low_speed_osc_i(1'b0), .watchdog_prescaler_out_i(1'b0),
    .t_zero_overflow_flag_o(flag0), .t_one_overflow_flag_o(flag1), .pwm_o(pwm));

  // ************************************************
  // shared helpers
  // ************************************************
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    logic v;
    i_core.read(pg, a, d, v);
    chk({7'h00, v}, 8'h01, "read valid");
    chk(d, exp, what);
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_core.access(1'b1, 4'h0, a, d);
  endtask : wr

  task automatic wpg(input logic [3:0] pg, input logic [7:0] d);
    i_core.access(1'b1, pg, DTC_ADDR_PAGED, d);
  endtask : wpg

  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    gsrc <= 4'h0;
    t0_pin <= 4'h0;
    @(posedge clk);
  endtask : do_reset

  // bounded wait for the selected flags
  task automatic wait_flag(input logic [1:0] sel);
    int n;
    n = 0;
    while ((({flag1, flag0} & sel) !== sel) && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if ((({flag1, flag0} & sel) !== sel))
    begin
      miscompares++;
      $display("mismatch at %0t ns: flag never set", $time);
      finish_test();
    end
  endtask : wait_flag

  // ************************************************
  // scenarios
  // ************************************************
  task automatic sc_regs;
    for (int i = 0; i < 6; i++)
      rd_chk(4'h0, 8'h88 + 8'(i), DTC_RESET_BYTE, "reset value");
    rd_chk(4'h0, DTC_ADDR_CLK_SEL, 8'h00, "clock select reset");
    rd_chk(4'h6, DTC_ADDR_PAGED, 8'h00, "gate page reset");
    wr(DTC_ADDR_MODE, 8'h5a);
    rd_chk(4'h0, DTC_ADDR_MODE, 8'h5a, "mode readback");
    wr(DTC_ADDR_CLK_SEL, 8'hff);
    rd_chk(4'h0, DTC_ADDR_CLK_SEL, 8'h0f, "clock select bits");
    wpg(4'h0, 8'hff);
    wpg(4'h1, 8'hff);
    wpg(4'h6, 8'hff);
    rd_chk(4'h0, DTC_ADDR_PAGED, 8'hc1, "page 0 fields");
    rd_chk(4'h1, DTC_ADDR_PAGED, 8'h30, "page 1 fields");
    rd_chk(4'h6, DTC_ADDR_PAGED, 8'h30, "page 6 fields");
    rd_chk(4'h2, DTC_ADDR_PAGED, 8'h00, "unmapped page");
    rd_chk(4'h0, 8'h90, 8'h00, "unmapped address");
  endtask : sc_regs

  task automatic sc_count16;
    wr(DTC_ADDR_MODE, 8'h01);
    wr(DTC_ADDR_CLK_SEL, 8'h04);
    wr(DTC_ADDR_T0_LOW, 8'hfe);
    wr(DTC_ADDR_T0_HIGH, 8'hff);
    wr(DTC_ADDR_RUN_FLAG, 8'h10);
    wait_flag(2'b01);
    wr(DTC_ADDR_RUN_FLAG, 8'h20);
    rd_chk(4'h0, DTC_ADDR_T0_HIGH, 8'h00, "high byte carried");
    i_core.ack(2'b01);
    #1;
    chk({7'h00, flag0}, 8'h00, "flag after vector");
  endtask : sc_count16

  task automatic sc_hold;
    wr(DTC_ADDR_T0_LOW, 8'h33);
    wr(DTC_ADDR_MODE, 8'h01);
    wr(DTC_ADDR_CLK_SEL, 8'h04);
    repeat (20) @(posedge clk);
    rd_chk(4'h0, DTC_ADDR_T0_LOW, 8'h33, "stopped timer moved");
    wr(DTC_ADDR_MODE, 8'h33);
    wr(DTC_ADDR_T1_LOW, 8'h10);
    wr(DTC_ADDR_T0_HIGH, 8'hfe);
    wr(DTC_ADDR_CLK_SEL, 8'h0c);
    wr(DTC_ADDR_RUN_FLAG, 8'h40);
    wait_flag(2'b10);
    rd_chk(4'h0, DTC_ADDR_T0_LOW, 8'h33, "split low byte moved");
    repeat (20) @(posedge clk);
    rd_chk(4'h0, DTC_ADDR_T1_LOW, 8'h10, "mode 3 timer moved");
  endtask : sc_hold

  task automatic sc_reload;
    logic [7:0] d;
    logic v;
    wr(DTC_ADDR_MODE, 8'ha0);
    wr(DTC_ADDR_CLK_SEL, 8'h08);
    wr(DTC_ADDR_T1_HIGH, 8'hf0);
    wr(DTC_ADDR_T1_LOW, 8'hfe);
    gsrc <= 4'b1000;
    wr(DTC_ADDR_RUN_FLAG, 8'h40);
    wait_flag(2'b10);
    repeat (30) @(posedge clk);
    wr(DTC_ADDR_RUN_FLAG, 8'h00);
    rd_chk(4'h0, DTC_ADDR_T1_HIGH, 8'hf0, "reload value changed");
    i_core.read(4'h0, DTC_ADDR_T1_LOW, d, v);
    chk({7'h00, d >= 8'hf0}, 8'h01, "low byte left reload range");
  endtask : sc_reload

  task automatic sc_gate;
    logic [7:0] d;
    logic v;
    for (int c = 1; c < 4; c++)
    begin
      wpg(4'h6, {3'b000, c[1], 4'h0});
      wr(DTC_ADDR_MODE, {4'h0, c[0], 3'b001});
      wr(DTC_ADDR_CLK_SEL, 8'h04);
      wr(DTC_ADDR_T0_LOW, 8'h00);
      wr(DTC_ADDR_RUN_FLAG, 8'h10);
      repeat (10) @(posedge clk);
      wr(DTC_ADDR_RUN_FLAG, 8'h00);
      rd_chk(4'h0, DTC_ADDR_T0_LOW, 8'h00, "counted with gate low");
      @(posedge clk);
      gsrc <= 4'(1 << (c - 1));
      wr(DTC_ADDR_RUN_FLAG, 8'h10);
      repeat (10) @(posedge clk);
      wr(DTC_ADDR_RUN_FLAG, 8'h00);
      i_core.read(4'h0, DTC_ADDR_T0_LOW, d, v);
      chk(d, 8'h0c, "count with gate high");
      @(posedge clk);
      gsrc <= 4'h0;
    end
  endtask : sc_gate

  task automatic sc_pin;
    wr(DTC_ADDR_MODE, 8'h04);
    wpg(4'h0, 8'h80);
    wr(DTC_ADDR_RUN_FLAG, 8'h10);
    for (int i = 0; i < 5; i++)
    begin
      t0_pin <= (i < 3) ? 4'b0101 : 4'b0001;
      repeat (4) @(posedge clk);
      t0_pin <= 4'b0000;
      repeat (4) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    wr(DTC_ADDR_RUN_FLAG, 8'h00);
    rd_chk(4'h0, DTC_ADDR_T0_LOW, 8'h03, "falling edges on routed pin");
  endtask : sc_pin

  task automatic sc_clkout;
    int n0, n1;
    logic [3:0] p0, p1;
    n0 = 0;
    n1 = 0;
    wr(DTC_ADDR_CLK_SEL, 8'h0f);
    wpg(4'h0, 8'h40);
    wpg(4'h1, 8'h30);
    #1;
    chk({4'h0, oe0}, 8'h02, "timer zero output pin");
    chk({4'h0, oe1}, 8'h08, "timer one output pin");
    wr(DTC_ADDR_T0_HIGH, 8'hfc);
    wr(DTC_ADDR_T0_LOW, 8'hfc);
    wr(DTC_ADDR_T1_HIGH, 8'hfe);
    wr(DTC_ADDR_T1_LOW, 8'hfe);
    wr(DTC_ADDR_RUN_FLAG, 8'h50);
    p0 = pin0;
    p1 = pin1;
    // count level changes on the routed pins
    repeat (64)
    begin
      @(posedge clk);
      #1;
      n0 += int'(pin0 != p0);
      n1 += int'(pin1 != p1);
      p0 = pin0;
      p1 = pin1;
    end
    chk({7'h00, n0 >= 8}, 8'h01, "timer zero clock toggles");
    chk({7'h00, n1 >= 8}, 8'h01, "timer one clock toggles");
    chk({6'h00, flag1, flag0}, 8'h00, "flag in clock-out");
    wr(DTC_ADDR_CLK_SEL, 8'h00);
    #1;
    chk({oe1, oe0}, 8'h00, "output left enabled");
  endtask : sc_clkout

  task automatic sc_flags;
    wr(DTC_ADDR_RUN_FLAG, 8'ha0);
    #1;
    chk({6'h00, flag1, flag0}, 8'h03, "software set flags");
    i_core.ack(2'b01);
    #1;
    chk({6'h00, flag1, flag0}, 8'h02, "vector clears one flag");
    wr(DTC_ADDR_RUN_FLAG, 8'h00);
    #1;
    chk({6'h00, flag1, flag0}, 8'h00, "software clear flags");
    wr(DTC_ADDR_T0_HIGH, 8'h40);
    @(posedge clk);
    #1;
    chk({6'h00, pwm}, 8'h01, "pwm level");
  endtask : sc_flags

  // ************************************************
  // main sequence and hang guard
  // ************************************************
  initial
  begin
    do_reset();
    sc_regs();
    do_reset();
    sc_count16();
    do_reset();
    sc_hold();
    do_reset();
    sc_reload();
    do_reset();
    sc_gate();
    do_reset();
    sc_pin();
    do_reset();
    sc_clkout();
    do_reset();
    sc_flags();
    finish_test();
  end

  initial
  begin
    repeat (50000) @(posedge clk);
    miscompares++;
    $display("mismatch at %0t ns: run timed out", $time);
    finish_test();
  end
endmodule : dual_timer_counter_control_test
